// [fbr_pkg.sv]
// fbr_pkg: register map, field positions, reset values and widths for the fieldbus host registers
package fbr_pkg;

  // ==========================================================================
  // register offsets
  // ==========================================================================
  localparam logic [5:0] OFS_BYTE_PORT     = 6'h00;
  localparam logic [5:0] OFS_LINE_CTRL_A   = 6'h01;
  localparam logic [5:0] OFS_LINE_CTRL_B   = 6'h02;
  localparam logic [5:0] OFS_CLOCK_INDEX   = 6'h03;
  localparam logic [5:0] OFS_COMM_IRQ      = 6'h04;
  localparam logic [5:0] OFS_ADDR_IRQ      = 6'h05;
  localparam logic [5:0] OFS_TIMER_IRQ     = 6'h06;
  localparam logic [5:0] OFS_ERROR_IRQ     = 6'h07;
  localparam logic [5:0] OFS_COMM_MASK     = 6'h08;
  localparam logic [5:0] OFS_ADDR_MASK     = 6'h09;
  localparam logic [5:0] OFS_TIMER_MASK    = 6'h0a;
  localparam logic [5:0] OFS_ERROR_MASK    = 6'h0b;
  localparam logic [5:0] OFS_SRAM_CLK_DIV  = 6'h26;

  // ==========================================================================
  // field widths and positions
  // ==========================================================================
  localparam int          ADDR_W           = 6;
  localparam int          DATA_W           = 8;
  localparam int          BAUD_W           = 5;
  localparam int          SRAM_DIV_W       = 4;
  localparam logic [7:0]  LINE_A_USED      = 8'h3f;
  localparam logic [7:0]  LINE_B_USED      = 8'h1f;
  localparam logic [7:0]  COMM_USED        = 8'hff;
  localparam logic [7:0]  ADDR_USED        = 8'h0f;
  localparam logic [7:0]  TIMER_USED       = 8'h3f;
  localparam logic [7:0]  ERROR_USED       = 8'h7f;
  localparam logic [7:0]  SRAM_DIV_USED    = 8'h0f;
  localparam int          LA_PREAMBLE_LSB  = 0;
  localparam int          LA_TX_CHECK      = 2;
  localparam int          LA_TX_ENABLE     = 3;
  localparam int          LA_DUPLEX        = 4;
  localparam int          LA_RX_ENABLE     = 5;
  localparam int          LB_ADDR_RECOG    = 0;
  localparam int          LB_DMA_RX        = 1;
  localparam int          LB_DMA_TX        = 2;
  localparam int          LB_LOOP          = 3;
  localparam int          LB_MEDIUM        = 4;
  localparam int          CC_BAUD_LSB      = 0;
  localparam int          CC_MODE_LSB      = 5;
  localparam int          CC_SOURCE        = 7;
  localparam logic [1:0]  MODE_STOPPED     = 2'b11;
  localparam int          COMM_TX_EMPTY    = 0;
  localparam int          COMM_RX_FULL     = 7;
  localparam int          IDX_EXTERNAL     = 7;

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [7:0]  RST_CTRL         = 8'h00;
  localparam logic [7:0]  RST_MASK         = 8'hff;
  localparam logic [7:0]  RST_TIMER_IRQ    = 8'h2a;
  localparam logic [7:0]  RST_OTHER_IRQ    = 8'h00;

endpackage : fbr_pkg

// [fbr_clk_div.sv]
// fbr_clk_div: tick divider that emits one pulse every (divisor + 1) input ticks
`timescale 1ns/1ps
module fbr_clk_div #(
  parameter int W = 5
) (
  input  wire logic         i_clock,
  input  wire logic         i_rst_n,
  input  wire logic         i_clock_en,
  input  wire logic         i_tick,
  input  wire logic         i_run,
  input  wire logic [W-1:0] i_divisor,
  output logic              o_pulse
);

  logic [W-1:0] count_reg;
  logic         wrap;

  assign wrap = (count_reg >= i_divisor);

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      count_reg <= '0;
      o_pulse   <= 1'b0;
    end
    else if (i_clock_en)
    begin
      if (!i_run)
      begin
        count_reg <= '0;
        o_pulse   <= 1'b0;
      end
      else if (i_tick)
      begin
        count_reg <= wrap ? '0 : W'(count_reg + 1'b1);
        o_pulse   <= wrap;
      end
      else
      begin
        o_pulse   <= 1'b0;
      end
    end
  end

endmodule : fbr_clk_div

// [fbr_regs.sv]
// fbr_regs: host register bank of the fieldbus controller, byte bus slave and event flags
//
// Functional notes
// - host write at 0x00 sends byte out
// - dma mode fetches bytes and clears flags itself
// - write while idle only starts transmission
// - read at 0x00 returns latest received byte
// - dma receive stores each byte to sram
// - control register a holds enable bits
// - preamble field selects one to four bytes
// - medium enable gates transmit enable output
// - loop bit routes transmit to receiver
// - control b holds dma and recognition enables
// - clock source bit picks system or line clock
// - rate mode 11 stops internal clock
// - baud divider gives input over value+1
// - sram divider gives system over value+1
// - index register ors the four status registers
// - irq output low when any summary set
// - status readable, write one clears bit
// - communication event bits set by hardware
// - address event bits set, top four zero
// - timer compare and wrap bits, compares set
// - cleared mask clears and blocks its bit
`timescale 1ns/1ps
module fbr_regs
  import fbr_pkg::*;
(
  input  wire logic              i_clock,
  input  wire logic              i_rst_n,
  input  wire logic              i_clock_en,
  // host byte bus
  input  wire logic              i_reg_cs_n,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  output logic      [DATA_W-1:0] o_rdata,
  // transmitter side
  input  wire logic              i_tx_idle,
  input  wire logic              i_tx_active,
  input  wire logic              i_tx_byte_req,
  input  wire logic              i_tx_done,
  output logic      [DATA_W-1:0] o_tx_byte,
  output logic                   o_tx_byte_valid,
  output logic                   o_tx_start,
  output logic                   o_mau_tx_en,
  // dma transmit fetch from sram
  output logic                   o_dma_fetch,
  input  wire logic              i_dma_valid,
  input  wire logic [DATA_W-1:0] i_dma_byte,
  // receiver side
  input  wire logic              i_rx_valid,
  input  wire logic [DATA_W-1:0] i_rx_byte,
  input  wire logic              i_rx_done,
  input  wire logic              i_end_delim,
  input  wire logic              i_rx_overflow,
  input  wire logic              i_start_delim,
  input  wire logic              i_carrier,
  output logic                   o_sram_wr,
  output logic      [DATA_W-1:0] o_sram_wdata,
  // other event sources
  input  wire logic [3:0]        i_addr_events,
  input  wire logic [5:0]        i_timer_events,
  input  wire logic [6:0]        i_error_events,
  input  wire logic              i_external_irq_in_n,
  output logic                   o_irq_request_out_n,
  // configuration to the line logic
  output logic                   o_receive_enable,
  output logic                   o_transmit_enable,
  output logic                   o_duplex_select,
  output logic                   o_tx_check_enable,
  output logic      [1:0]        o_preamble_length,
  output logic                   o_internal_loop,
  output logic                   o_dma_tx_enable,
  output logic                   o_dma_rx_enable,
  output logic                   o_addr_recog_enable,
  output logic                   o_rate_active,
  // clocking
  input  wire logic              i_line_clock_input,
  output logic                   o_tick_500k,
  output logic                   o_sram_clk_tick
);

  // ==========================================================================
  // bus decode
  // ==========================================================================
  logic wr_en, rd_en, wr_byte_port, wr_line_a, wr_line_b, wr_clock, wr_sram_div;
  logic wr_comm, wr_addr, wr_timer, wr_error;
  logic wr_comm_mask, wr_addr_mask, wr_timer_mask, wr_error_mask;

  assign wr_en         = !i_reg_cs_n && i_wr;
  assign rd_en         = !i_reg_cs_n && i_rd;
  assign wr_byte_port  = wr_en && (i_addr == OFS_BYTE_PORT);
  assign wr_line_a     = wr_en && (i_addr == OFS_LINE_CTRL_A);
  assign wr_line_b     = wr_en && (i_addr == OFS_LINE_CTRL_B);
  assign wr_clock      = wr_en && (i_addr == OFS_CLOCK_INDEX);
  assign wr_sram_div   = wr_en && (i_addr == OFS_SRAM_CLK_DIV);
  assign wr_comm       = wr_en && (i_addr == OFS_COMM_IRQ);
  assign wr_addr       = wr_en && (i_addr == OFS_ADDR_IRQ);
  assign wr_timer      = wr_en && (i_addr == OFS_TIMER_IRQ);
  assign wr_error      = wr_en && (i_addr == OFS_ERROR_IRQ);
  assign wr_comm_mask  = wr_en && (i_addr == OFS_COMM_MASK);
  assign wr_addr_mask  = wr_en && (i_addr == OFS_ADDR_MASK);
  assign wr_timer_mask = wr_en && (i_addr == OFS_TIMER_MASK);
  assign wr_error_mask = wr_en && (i_addr == OFS_ERROR_MASK);

  // ==========================================================================
  // control registers
  // ==========================================================================
  logic [7:0] line_control_a_reg, line_control_b_reg;
  logic [7:0] clock_control_reg, sram_clock_divider_reg;

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      line_control_a_reg     <= RST_CTRL;
      line_control_b_reg     <= RST_CTRL;
      clock_control_reg      <= RST_CTRL;
      sram_clock_divider_reg <= RST_CTRL;
    end
    else if (i_clock_en)
    begin
      if (wr_line_a)
        line_control_a_reg <= i_wdata & LINE_A_USED;
      if (wr_line_b)
        line_control_b_reg <= i_wdata & LINE_B_USED;
      if (wr_clock)
        clock_control_reg <= i_wdata;
      if (wr_sram_div)
        sram_clock_divider_reg <= i_wdata & SRAM_DIV_USED;
    end
  end

  // configuration outputs come straight from the register flops
  assign o_preamble_length   = line_control_a_reg[LA_PREAMBLE_LSB +: 2];
  assign o_tx_check_enable   = line_control_a_reg[LA_TX_CHECK];
  assign o_transmit_enable   = line_control_a_reg[LA_TX_ENABLE];
  assign o_duplex_select     = line_control_a_reg[LA_DUPLEX];
  assign o_receive_enable    = line_control_a_reg[LA_RX_ENABLE];
  assign o_addr_recog_enable = line_control_b_reg[LB_ADDR_RECOG];
  assign o_dma_rx_enable     = line_control_b_reg[LB_DMA_RX];
  assign o_dma_tx_enable     = line_control_b_reg[LB_DMA_TX];
  assign o_internal_loop     = line_control_b_reg[LB_LOOP];

  logic medium_enable, dma_tx, dma_rx, line_clock_source;
  logic [1:0]        rate_mode_select;
  logic [BAUD_W-1:0] baud_divider;

  assign medium_enable     = line_control_b_reg[LB_MEDIUM];
  assign dma_tx            = line_control_b_reg[LB_DMA_TX];
  assign dma_rx            = line_control_b_reg[LB_DMA_RX];
  assign rate_mode_select  = clock_control_reg[CC_MODE_LSB +: 2];
  assign line_clock_source = clock_control_reg[CC_SOURCE];
  assign baud_divider      = clock_control_reg[CC_BAUD_LSB +: BAUD_W];

  // ==========================================================================
  // transmit path
  // ==========================================================================
  // a write that lands while the transmitter is idle kicks off a frame only;
  // the byte it carries is deliberately thrown away
  logic tx_kick, tx_host_byte, tx_dma_req;

  assign tx_kick      = wr_byte_port && i_tx_idle;
  assign tx_host_byte = wr_byte_port && !i_tx_idle && !dma_tx;
  assign tx_dma_req   = dma_tx && i_tx_byte_req;

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_tx_byte       <= '0;
      o_tx_byte_valid <= 1'b0;
      o_tx_start      <= 1'b0;
      o_dma_fetch     <= 1'b0;
      o_mau_tx_en     <= 1'b0;
    end
    else if (i_clock_en)
    begin
      o_tx_start      <= tx_kick;
      o_dma_fetch     <= tx_dma_req;
      o_tx_byte_valid <= tx_host_byte || (dma_tx && i_dma_valid);
      if (tx_host_byte)
        o_tx_byte <= i_wdata;
      else if (dma_tx && i_dma_valid)
        o_tx_byte <= i_dma_byte;
      o_mau_tx_en     <= i_tx_active && medium_enable;
    end
  end

  // ==========================================================================
  // receive path
  // ==========================================================================
  logic [DATA_W-1:0] rx_byte_port_reg;

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rx_byte_port_reg <= '0;
      o_sram_wr        <= 1'b0;
      o_sram_wdata     <= '0;
    end
    else if (i_clock_en)
    begin
      if (i_rx_valid)
        rx_byte_port_reg <= i_rx_byte;
      o_sram_wr <= i_rx_valid && dma_rx;
      if (i_rx_valid && dma_rx)
        o_sram_wdata <= i_rx_byte;
    end
  end

  // ==========================================================================
  // interrupt status and masks
  // ==========================================================================
  // in dma mode the byte handshakes are consumed internally, so each of those two
  // flags never reaches software while its own dma direction (rx or tx) is on and cannot flood the irq line
  logic [7:0] comm_events, addr_events, timer_events, error_events;
  assign comm_events = {i_rx_valid && !dma_rx, i_carrier, i_start_delim, i_rx_overflow,
                        i_end_delim, i_rx_done, i_tx_done,
                        i_tx_byte_req && !dma_tx};
  assign addr_events  = {4'h0, i_addr_events};
  assign timer_events = {2'h0, i_timer_events};
  assign error_events = {1'b0, i_error_events};
  logic [7:0] comm_irq_status_reg, addr_irq_status_reg, timer_irq_status_reg;
  logic [7:0] error_irq_status_reg, comm_irq_status_next, addr_irq_status_next;
  logic [7:0] timer_irq_status_next, error_irq_status_next;
  logic [7:0] comm_mask_reg, addr_mask_reg, timer_mask_reg, error_mask_reg;
  logic [7:0] comm_clr, addr_clr, timer_clr, error_clr;
  assign comm_clr  = wr_comm  ? i_wdata : 8'h00;
  assign addr_clr  = wr_addr  ? i_wdata : 8'h00;
  assign timer_clr = wr_timer ? i_wdata : 8'h00;
  assign error_clr = wr_error ? i_wdata : 8'h00;

  // a new event beats a clear in the same cycle; a zero mask bit wipes the flag
  assign comm_irq_status_next  = ((comm_irq_status_reg & ~comm_clr) | comm_events)
                                 & comm_mask_reg & COMM_USED;
  assign addr_irq_status_next  = ((addr_irq_status_reg & ~addr_clr) | addr_events)
                                 & addr_mask_reg & ADDR_USED;
  assign timer_irq_status_next = ((timer_irq_status_reg & ~timer_clr) | timer_events)
                                 & timer_mask_reg & TIMER_USED;
  assign error_irq_status_next = ((error_irq_status_reg & ~error_clr) | error_events)
                                 & error_mask_reg & ERROR_USED;

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      comm_irq_status_reg  <= RST_OTHER_IRQ;
      addr_irq_status_reg  <= RST_OTHER_IRQ;
      timer_irq_status_reg <= RST_TIMER_IRQ;
      error_irq_status_reg <= RST_OTHER_IRQ;
    end
    else if (i_clock_en)
    begin
      comm_irq_status_reg  <= comm_irq_status_next;
      addr_irq_status_reg  <= addr_irq_status_next;
      timer_irq_status_reg <= timer_irq_status_next;
      error_irq_status_reg <= error_irq_status_next;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      comm_mask_reg  <= RST_MASK & COMM_USED;
      addr_mask_reg  <= RST_MASK & ADDR_USED;
      timer_mask_reg <= RST_MASK & TIMER_USED;
      error_mask_reg <= RST_MASK & ERROR_USED;
    end
    else if (i_clock_en)
    begin
      if (wr_comm_mask)
        comm_mask_reg <= i_wdata & COMM_USED;
      if (wr_addr_mask)
        addr_mask_reg <= i_wdata & ADDR_USED;
      if (wr_timer_mask)
        timer_mask_reg <= i_wdata & TIMER_USED;
      if (wr_error_mask)
        error_mask_reg <= i_wdata & ERROR_USED;
    end
  end

  // ==========================================================================
  // interrupt index and request line
  // ==========================================================================
  logic [3:0] source_flags;
  logic [7:0] irq_source_index;
  assign source_flags = {|error_irq_status_reg, |timer_irq_status_reg,
                         |addr_irq_status_reg, |comm_irq_status_reg};
  assign irq_source_index = {!i_external_irq_in_n, 3'h0, source_flags};

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_irq_request_out_n <= 1'b1;
    else if (i_clock_en)
      o_irq_request_out_n <= !(|source_flags);
  end

  // ==========================================================================
  // read data
  // ==========================================================================
  // write-only cells (tx port, clock control) share offsets with readable
  // ones, so reads there return the readable register
  logic [7:0]        rd_mux;

  always_comb
  begin
    rd_mux = 8'h00;
    case (i_addr)
      OFS_BYTE_PORT:    rd_mux = rx_byte_port_reg;
      OFS_LINE_CTRL_A:  rd_mux = line_control_a_reg;
      OFS_LINE_CTRL_B:  rd_mux = line_control_b_reg;
      OFS_CLOCK_INDEX:  rd_mux = irq_source_index;
      OFS_COMM_IRQ:     rd_mux = comm_irq_status_reg;
      OFS_ADDR_IRQ:     rd_mux = addr_irq_status_reg;
      OFS_TIMER_IRQ:    rd_mux = timer_irq_status_reg;
      OFS_ERROR_IRQ:    rd_mux = error_irq_status_reg;
      OFS_COMM_MASK:    rd_mux = comm_mask_reg;
      OFS_ADDR_MASK:    rd_mux = addr_mask_reg;
      OFS_TIMER_MASK:   rd_mux = timer_mask_reg;
      OFS_ERROR_MASK:   rd_mux = error_mask_reg;
      OFS_SRAM_CLK_DIV: rd_mux = sram_clock_divider_reg;
      default:          rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_rdata <= '0;
    else if (i_clock_en && rd_en)
      o_rdata <= rd_mux;
  end

  // ==========================================================================
  // clock generation
  // ==========================================================================
  // the line clock pin is sampled as a plain input; its rising edge counts as
  // one input tick, so it must run well below the system clock
  logic line_clk_q, line_tick, baud_tick_in, rate_run;
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      line_clk_q    <= 1'b0;
      o_rate_active <= 1'b0;
    end
    else if (i_clock_en)
    begin
      line_clk_q    <= i_line_clock_input;
      o_rate_active <= rate_run;
    end
  end

  assign line_tick    = i_line_clock_input && !line_clk_q;
  assign baud_tick_in = line_clock_source ? line_tick : 1'b1;
  assign rate_run     = (rate_mode_select != MODE_STOPPED);

  fbr_clk_div #(
    .W          (BAUD_W)
  ) u_baud_div (
    .i_clock    (i_clock),
    .i_rst_n    (i_rst_n),
    .i_clock_en (i_clock_en),
    .i_tick     (baud_tick_in),
    .i_run      (rate_run),
    .i_divisor  (baud_divider),
    .o_pulse    (o_tick_500k)
  );

  fbr_clk_div #(
    .W          (SRAM_DIV_W)
  ) u_sram_div (
    .i_clock    (i_clock),
    .i_rst_n    (i_rst_n),
    .i_clock_en (i_clock_en),
    .i_tick     (1'b1),
    .i_run      (1'b1),
    .i_divisor  (sram_clock_divider_reg[SRAM_DIV_W-1:0]),
    .o_pulse    (o_sram_clk_tick)
  );

endmodule : fbr_regs

// [fbr_regs_assertions.sv]
// fbr_regs_assertions.sv: port checker for the host register bank
`timescale 1ns/1ps
module fbr_chk
  import fbr_pkg::*;
(
  input wire logic i_clock, i_rst_n, i_reg_cs_n, i_wr, i_tx_idle, i_tx_active,
  input wire logic i_tx_byte_req, i_dma_valid, i_rx_valid, o_tx_byte_valid, o_tx_start,
  input wire logic o_mau_tx_en, o_dma_fetch, o_sram_wr, o_dma_tx_enable, o_dma_rx_enable,
  input wire logic o_rate_active, o_tick_500k,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata, i_rx_byte, o_tx_byte, o_sram_wdata
);
  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  sequence port_wr;
    !i_reg_cs_n && i_wr && i_addr == OFS_BYTE_PORT;
  endsequence
  idle_start_a:
    assert property (port_wr ##0 i_tx_idle |=> o_tx_start && !o_tx_byte_valid)
    else $error("idle write did not only start");
  byte_send_a:
    assert property (port_wr ##0 !i_tx_idle && !o_dma_tx_enable
      |=> o_tx_byte_valid && o_tx_byte == $past(i_wdata))
    else $error("written byte not sent");
  dma_ignore_a:
    assert property (port_wr ##0 !i_tx_idle && o_dma_tx_enable && !i_dma_valid
      |=> !o_tx_byte_valid)
    else $error("host byte taken in dma mode");
  dma_fetch_a:
    assert property (o_dma_tx_enable && i_tx_byte_req |=> o_dma_fetch)
    else $error("no fetch on byte request");
  sram_store_a:
    assert property (o_dma_rx_enable && i_rx_valid
      |=> o_sram_wr && o_sram_wdata == $past(i_rx_byte))
    else $error("received byte not stored");
  sram_quiet_a:
    assert property (!o_dma_rx_enable |=> !o_sram_wr)
    else $error("store without dma receive");
  mau_gate_a:
    assert property (o_mau_tx_en |-> $past(i_tx_active))
    else $error("medium enable outside transmission");
  clock_stop_a:
    assert property (!o_rate_active [*2] |-> !o_tick_500k)
    else $error("tick while clock stopped");
endmodule : fbr_chk

bind fbr_regs fbr_chk u_chk (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_reg_cs_n(i_reg_cs_n),
  .i_wr(i_wr), .i_tx_idle(i_tx_idle), .i_tx_active(i_tx_active),
  .i_tx_byte_req(i_tx_byte_req), .i_dma_valid(i_dma_valid), .i_rx_valid(i_rx_valid),
  .o_tx_byte_valid(o_tx_byte_valid), .o_tx_start(o_tx_start), .o_mau_tx_en(o_mau_tx_en),
  .o_dma_fetch(o_dma_fetch), .o_sram_wr(o_sram_wr), .o_dma_tx_enable(o_dma_tx_enable),
  .o_dma_rx_enable(o_dma_rx_enable), .o_rate_active(o_rate_active),
  .o_tick_500k(o_tick_500k), .i_addr(i_addr), .i_wdata(i_wdata), .i_rx_byte(i_rx_byte),
  .o_tx_byte(o_tx_byte), .o_sram_wdata(o_sram_wdata));

// [fbr_host_model.sv]
// fbr_host_model.sv: byte bus host that polls, sends and receives
`timescale 1ns/1ps
module fbr_host_model
  import fbr_pkg::*;
(
  input  wire logic              i_clock,
  input  wire logic [DATA_W-1:0] i_rdata,
  output logic                   o_cs_n,
  output logic                   o_wr,
  output logic                   o_rd,
  output logic      [ADDR_W-1:0] o_addr,
  output logic      [DATA_W-1:0] o_wdata
);
  // ==========================================================================
  // bus cycles; released lines show inverted values so stale data never passes
  // ==========================================================================
  initial {o_cs_n, o_wr, o_rd, o_addr, o_wdata} = 17'h10000;
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_clock);
    #1 {o_cs_n, o_wr, o_addr, o_wdata} = {2'b01, a, d};
    @(posedge i_clock);
    #1 {o_cs_n, o_wr, o_addr, o_wdata} = {2'b10, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge i_clock);
    #1 {o_cs_n, o_rd, o_addr} = {2'b01, a};
    @(posedge i_clock);
    #1 {o_cs_n, o_rd, o_addr} = {2'b10, ~a};
    d = i_rdata;
  endtask : rd
  // gives up after 16 reads so a missing flag cannot hang the run
  task automatic poll(input int b, output logic ok);
    logic [7:0] s;
    ok = 1'b0;
    for (int n = 0; n < 16 && !ok; n++)
    begin
      rd(OFS_COMM_IRQ, s);
      ok = s[b];
    end
  endtask : poll
  task automatic send(input logic [7:0] d, output logic ok);
    poll(COMM_TX_EMPTY, ok);
    wr(OFS_BYTE_PORT, d);
    wr(OFS_COMM_IRQ, 8'h01);
  endtask : send
  task automatic recv(output logic [7:0] d, output logic ok);
    poll(COMM_RX_FULL, ok);
    rd(OFS_BYTE_PORT, d);
  endtask : recv
endmodule : fbr_host_model

// [fieldbus_host_control_regs_tb_top.sv]
// fieldbus_host_control_regs_tb_top.sv: self-checking bench for the host register bank
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module fieldbus_host_control_regs_tb_top
  import fbr_pkg::*;
;
  typedef struct packed {logic [5:0] a; logic [7:0] w; logic [7:0] e;} fbr_row_s;
  localparam fbr_row_s ROWS [5] = '{'{6'h01, 8'hff, 8'h3f}, '{6'h02, 8'hff, 8'h1f},
    '{6'h26, 8'h0f, 8'h0f}, '{6'h3f, 8'hff, 8'h00}, '{6'h09, 8'hf3, 8'h03}};
  logic clk = 0, rst_n = 0, tx_idle = 0, tx_act = 0, req = 0, dv = 0, rv = 0, ext_n = 1, ok;
  logic [5:0] evt = 0;
  logic [3:0] aev = 0;
  logic [7:0] db = 0, rb = 0, d;
  int failures = 0, samples_checked = 0, t1, t2;
  wire cs_n, wr, rd, tx_start, mau, irq_n, re, te, dup, chk, rate, tick, stick;
  wire [5:0] addr;
  wire [7:0] wdata, rdata, tx_byte;
  wire [1:0] pre;
  always #20 clk = ~clk;
  fbr_host_model u_host (.i_clock(clk), .i_rdata(rdata), .o_cs_n(cs_n), .o_wr(wr),
    .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
  fbr_regs uut (.i_clock(clk), .i_rst_n(rst_n), .i_clock_en(1'b1), .i_reg_cs_n(cs_n),
    .i_wr(wr), .i_rd(rd), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
    .i_tx_idle(tx_idle), .i_tx_active(tx_act), .i_tx_byte_req(req), .i_tx_done(evt[0]),
    .o_tx_byte(tx_byte), .o_tx_byte_valid(), .o_tx_start(tx_start), .o_mau_tx_en(mau),
    .o_dma_fetch(), .i_dma_valid(dv), .i_dma_byte(db), .i_rx_valid(rv), .i_rx_byte(rb),
    .i_rx_done(evt[1]), .i_end_delim(evt[2]), .i_rx_overflow(evt[3]),
    .i_start_delim(evt[4]), .i_carrier(evt[5]), .o_sram_wr(), .o_sram_wdata(),
    .i_addr_events(aev), .i_timer_events(6'h00), .i_error_events(7'h00),
    .i_external_irq_in_n(ext_n), .o_irq_request_out_n(irq_n), .o_receive_enable(re),
    .o_transmit_enable(te), .o_duplex_select(dup), .o_tx_check_enable(chk),
    .o_preamble_length(pre), .o_internal_loop(), .o_dma_tx_enable(), .o_dma_rx_enable(),
    .o_addr_recog_enable(), .o_rate_active(rate), .i_line_clock_input(1'b0),
    .o_tick_500k(tick), .o_sram_clk_tick(stick));
  // ==========================================================================
  // helpers
  // ==========================================================================
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step
  task automatic count(input int k);
    t1 = 0;
    t2 = 0;
    repeat (k)
    begin
      step(1);
      t1 += tick;
      t2 += stick;
    end
  endtask : count
  task automatic finish_test;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  // ==========================================================================
  // sequence
  // ==========================================================================
  initial
  begin
    step(2);
    rst_n = 1;
    u_host.rd(OFS_TIMER_IRQ, d); `CHK(d, 8'h2a)
    `CHK(irq_n, 1'b0)
    u_host.rd(OFS_CLOCK_INDEX, d); `CHK(d, 8'h04)
    u_host.wr(OFS_TIMER_IRQ, 8'h2a);
    u_host.rd(OFS_TIMER_IRQ, d); `CHK(d, 8'h00)
    step(1); `CHK(irq_n, 1'b1)
    foreach (ROWS[i])
    begin
      u_host.wr(ROWS[i].a, ROWS[i].w);
      u_host.rd(ROWS[i].a, d); `CHK(d, ROWS[i].e)
    end
    u_host.wr(OFS_LINE_CTRL_A, 8'h21); `CHK({re, dup, te, chk, pre}, 6'b100001)
    {req, dv, db} = 10'h396;
    step(1);
    {req, dv, rv, rb} = 11'h1c3;
    `CHK(tx_byte, 8'h96)
    step(1);
    rv = 0;
    u_host.rd(OFS_COMM_IRQ, d); `CHK(d & 8'h81, 8'h00)
    u_host.wr(OFS_BYTE_PORT, 8'h11); `CHK(tx_byte, 8'h96)
    tx_act = 1;
    step(2); `CHK(mau, 1'b1)
    u_host.wr(OFS_LINE_CTRL_B, 8'h00);
    step(1); `CHK(mau, 1'b0)
    {tx_act, evt, aev} = 11'h3ff;
    step(1);
    {evt, aev, ext_n} = 11'h000;
    u_host.rd(OFS_CLOCK_INDEX, d); `CHK(d, 8'h83)
    u_host.rd(OFS_COMM_IRQ, d); `CHK(d, 8'h7e)
    u_host.rd(OFS_ADDR_IRQ, d); `CHK(d, 8'h03)
    u_host.wr(OFS_COMM_IRQ, 8'h7e);
    u_host.wr(OFS_COMM_MASK, 8'hbf);
    {evt, ext_n} = 7'h7f;
    step(1);
    evt = 0;
    u_host.rd(OFS_COMM_IRQ, d); `CHK(d, 8'h3e)
    u_host.wr(OFS_COMM_MASK, 8'hff);
    tx_idle = 1;
    u_host.wr(OFS_BYTE_PORT, 8'h11); `CHK(tx_start, 1'b1)
    {tx_idle, req} = 2'b01;
    step(1);
    req = 0;
    u_host.send(8'h5a, ok); `CHK({ok, tx_byte}, 9'h15a)
    {rv, rb} = 9'h13c;
    step(1);
    rv = 0;
    u_host.recv(d, ok); `CHK({ok, d}, 9'h13c)
    u_host.wr(OFS_CLOCK_INDEX, 8'h60);
    step(1); `CHK(rate, 1'b0)
    u_host.wr(OFS_CLOCK_INDEX, 8'h23);
    step(4);
    count(32); `CHK(t1, 8)
    `CHK(t2, 2)
    finish_test();
  end
endmodule : fieldbus_host_control_regs_tb_top
